// ==== pkg/terminal_io_pkg.sv ====
package terminal_io_pkg;

  // Clock and sampling
  localparam int CLK_HZ = 125_000_000;
  localparam int CLK_MHZ = 125;
  localparam int SAMPLE_PERIOD_US = 1000;
  localparam int SAMPLE_TICK_CYCLES = CLK_MHZ * SAMPLE_PERIOD_US;
  localparam int FILT_UNIT_US = 100_000;
  localparam int TAU_SAMPLES_PER_UNIT = FILT_UNIT_US / SAMPLE_PERIOD_US;
  localparam int FILT_FRAC = 16;

  // Scaling: config volts in 0.1 V, samples in 0.01 V or 0.01 mA
  localparam int CFG_V_TO_RAW = 10;
  localparam int CUR_TO_VOLT_DIV = 2;
  localparam int AO_MA_PER_HALF_V = 2;
  localparam int PCT_FULL = 1000;

  // Terminal command modes
  localparam logic [1:0] MODE_2W_DIR = 2'h0;
  localparam logic [1:0] MODE_2W_EN = 2'h1;
  localparam logic [1:0] MODE_3W_DIR = 2'h2;
  localparam logic [1:0] MODE_3W_SEP = 2'h3;
  localparam logic [1:0] MODE_DEFAULT = MODE_2W_DIR;
  localparam logic [4:0] FUNC_THREE_WIRE = 5'h03;

  // Up/down rate in 0.01 Hz/s
  localparam logic [13:0] RATE_MIN = 14'h0001;
  localparam logic [13:0] RATE_MAX = 14'h270f;
  localparam logic [13:0] RATE_DEFAULT = 14'h0032;

  // Digital output selection codes
  localparam logic [3:0] DO_NONE = 4'h0;
  localparam logic [3:0] DO_FREQ_REACHED = 4'h1;
  localparam logic [3:0] DO_LEVEL_DETECT = 4'h2;
  localparam logic [3:0] DO_FAULT = 4'h3;
  localparam logic [3:0] DO_FWD_RUN = 4'h4;
  localparam logic [3:0] DO_REV_RUN = 4'h5;
  localparam logic [3:0] DO_BELOW_START = 4'h6;
  localparam logic [3:0] DO_UPPER_LIMIT = 4'h7;
  localparam logic [3:0] DO_LOWER_LIMIT = 4'h8;
  localparam logic [3:0] TX_SEL_DEFAULT = 4'h1;
  localparam logic [3:0] RELAY_SEL_DEFAULT = 4'h3;

  // Analog output source codes
  localparam logic [3:0] AO_SET_FREQ = 4'h0;
  localparam logic [3:0] AO_RUN_FREQ = 4'h1;
  localparam logic [3:0] AO_CURRENT = 4'h2;
  localparam logic [3:0] AO_VOLTAGE = 4'h3;
  localparam logic [3:0] AO_SPEED = 4'h4;
  localparam logic [3:0] AO_POWER = 4'h5;
  localparam logic [3:0] AO_TORQUE = 4'h6;
  localparam logic [3:0] AO_VI = 4'h7;
  localparam logic [3:0] AO_CI = 4'h8;
  localparam logic [3:0] AO_SEL_DEFAULT = 4'h0;

  // Analog defaults
  localparam logic [6:0] AIN_LO_V_DEFAULT = 7'h00;
  localparam logic [11:0] AIN_LO_PCT_DEFAULT = 12'h000;
  localparam logic [6:0] AIN_HI_V_DEFAULT = 7'h64;
  localparam logic [11:0] AIN_HI_PCT_DEFAULT = 12'h3e8;
  localparam logic [6:0] AIN_FILT_DEFAULT = 7'h01;
  localparam logic [9:0] AO_LO_PCT_DEFAULT = 10'h000;
  localparam logic [6:0] AO_LO_LV_DEFAULT = 7'h00;
  localparam logic [9:0] AO_HI_PCT_DEFAULT = 10'h3e8;
  localparam logic [6:0] AO_HI_LV_DEFAULT = 7'h64;

  // Synchroniser vector layout
  localparam int PIN_FWD = 0;
  localparam int PIN_REV = 1;
  localparam int PIN_RUN = 2;
  localparam int PIN_STOP = 3;
  localparam int PIN_REVPB = 4;
  localparam int PIN_UP = 5;
  localparam int PIN_DOWN = 6;
  localparam int PIN_FIXED = 7;

  typedef struct packed {
    logic [6:0] lo_v;
    logic signed [11:0] lo_pct;
    logic [6:0] hi_v;
    logic signed [11:0] hi_pct;
    logic [6:0] filt_ds;
    logic is_current;
  } ain_cfg_t;

  typedef struct packed {
    logic [3:0] sel;
    logic [9:0] lo_pct;
    logic [6:0] lo_lv;
    logic [9:0] hi_pct;
    logic [6:0] hi_lv;
    logic is_current;
  } ao_cfg_t;

  typedef struct packed {
    logic freq_reached;
    logic level_detect;
    logic fault;
    logic fwd_running;
    logic rev_running;
    logic below_start;
    logic at_upper;
    logic at_lower;
  } drive_status_t;

  typedef struct packed {
    logic [9:0] set_freq;
    logic [9:0] run_freq;
    logic [9:0] current;
    logic [9:0] voltage;
    logic [9:0] speed;
    logic [9:0] power;
    logic [9:0] torque;
  } drive_meas_t;

endpackage : terminal_io_pkg

// ==== rtl/analog_input_scaler.sv ====
`timescale 1ns/1ps
module analog_input_scaler #(
  parameter int RAW_W = 11
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Sample and settings
  input wire logic sample_tick_in,
  input wire logic [RAW_W-1:0] raw_in,
  input wire terminal_io_pkg::ain_cfg_t cfg_in,
  // Scaled percent, 0.1 % units
  output logic signed [11:0] pct_out
);

  int v_raw;
  int v_lo;
  int v_hi;
  int v_cl;
  int span;
  int scaled;
  int tau;
  int step;
  logic signed [31:0] acc_r;

  always_comb begin
    v_raw = int'(raw_in);
    if (cfg_in.is_current) begin
      v_raw = int'(raw_in) / terminal_io_pkg::CUR_TO_VOLT_DIV;
    end
    v_lo = int'(cfg_in.lo_v) * terminal_io_pkg::CFG_V_TO_RAW;
    v_hi = int'(cfg_in.hi_v) * terminal_io_pkg::CFG_V_TO_RAW;
    v_cl = v_raw;
    if (v_raw < v_lo) begin
      v_cl = v_lo;
    end else if (v_raw > v_hi) begin
      v_cl = v_hi;
    end
    span = v_hi - v_lo;
    // Equal limits would divide by zero, so the lower setting is held
    if (span <= 0) begin
      scaled = int'(cfg_in.lo_pct);
    end else begin
      scaled = int'(cfg_in.lo_pct)
             + (v_cl - v_lo) * (int'(cfg_in.hi_pct) - int'(cfg_in.lo_pct)) / span;
    end
    tau = int'(cfg_in.filt_ds) * terminal_io_pkg::TAU_SAMPLES_PER_UNIT + 1;
    step = ((scaled <<< terminal_io_pkg::FILT_FRAC) - int'(acc_r)) / tau;
  end

  // Fractional bits keep long time constants from stalling on rounding
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      acc_r <= '0;
    end else if (sample_tick_in) begin
      acc_r <= acc_r + step;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      pct_out <= '0;
    end else begin
      pct_out <= acc_r[terminal_io_pkg::FILT_FRAC+11:terminal_io_pkg::FILT_FRAC];
    end
  end

  a_ain_clamp_low: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (sample_tick_in && cfg_in.filt_ds == 7'h00 && !cfg_in.is_current && v_raw <= v_lo
      && v_hi > v_lo)
    |-> ##2 (pct_out == $past(cfg_in.lo_pct, 2)))
    else $error("voltage below lower limit not clamped to lower setting");

endmodule : analog_input_scaler

// ==== rtl/terminal_command_io.sv ====
// Overview of operation
// - Mode 0..3 picks how terminals give run commands; default is mode 0.
// - Mode 0: forward alone runs forward, reverse alone reverse, none or both stop.
// - Mode 1: forward input enables; reverse input picks direction; no enable stops.
// - Mode 2: hold enables, run button starts, stop button stops, switch sets direction.
// - Mode 3: hold enables; run starts forward, reverse button reverse, stop stops.
// - Two-wire: after an outside stop, run needs a fresh activation to restart.
// - Up/down terminals move the setpoint at 0.01 to 99.99 Hz/s, default 0.50.
// - Voltage input maps linearly between limits to settings, clamped outside the span.
// - Default mapping: 0.0 V gives 0.0 %, 10.0 V gives 100.0 %.
// - Each input filter time is 0.0 to 10.0 s, default 0.1 s.
// - Current mode treats 0 to 20 mA as 0 to 10 V.
// - Current input has its own limits, settings and filter, applied alike.
// - Each digital output picks a status by code; transistor default 1, relay 3.
// - An output set to the fault code turns on as soon as a fault occurs.
// - Analog output source picked by code 0..8, default 0; 9 and 10 reserved.
// - Analog output maps source percent linearly to levels, clamped outside the span.
// - In current mode each milliampere of output equals 0.5 V of level.
// - Input terminal function code 3 marks the three-wire hold input.
`timescale 1ns/1ps
module terminal_command_io #(
  parameter int TERM_N = 4,
  parameter int AIN_W = 11,
  parameter int SAMPLE_TICK_CYCLES = terminal_io_pkg::SAMPLE_TICK_CYCLES,
  parameter int UPDOWN_DIV = terminal_io_pkg::CLK_HZ
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Terminal pins
  input wire logic forward_run_input_in,
  input wire logic reverse_run_input_in,
  input wire logic run_pushbutton_in,
  input wire logic stop_pushbutton_in,
  input wire logic reverse_pushbutton_in,
  input wire logic freq_up_in,
  input wire logic freq_down_in,
  input wire logic [TERM_N-1:0] input_terminal_x_in,
  // Configuration
  input wire logic [1:0] terminal_command_mode_param_in,
  input wire logic [TERM_N-1:0][4:0] term_func_in,
  input wire logic [13:0] updown_rate_param_in,
  input wire logic [15:0] max_freq_in,
  input wire terminal_io_pkg::ain_cfg_t vi_cfg_in,
  input wire terminal_io_pkg::ain_cfg_t ci_cfg_in,
  input wire logic [3:0] transistor_sel_in,
  input wire logic [3:0] relay_sel_in,
  input wire terminal_io_pkg::ao_cfg_t ao_cfg_in,
  // Drive state
  input wire logic ext_stop_in,
  input wire terminal_io_pkg::drive_status_t drive_status_in,
  input wire terminal_io_pkg::drive_meas_t drive_meas_in,
  // Analog samples
  input wire logic [AIN_W-1:0] voltage_analog_input_in,
  input wire logic [AIN_W-1:0] current_analog_input_in,
  // Run commands and setpoint
  output logic run_fwd_out,
  output logic run_rev_out,
  output logic [15:0] freq_setpoint_out,
  // Scaled analog inputs
  output logic signed [11:0] vi_pct_out,
  output logic signed [11:0] ci_pct_out,
  // Outputs to terminals
  output logic transistor_output_out,
  output logic relay_output_out,
  output logic [11:0] analog_output_out
);

  localparam int PIN_W = terminal_io_pkg::PIN_FIXED + TERM_N;
  logic [PIN_W-1:0] pin_raw, pin_s1_r, pin_s2_r, pin_s3_r, pin_c_r;
  logic fwd_c, rev_c, run_pb_c, stop_pb_c, rev_pb_c, up_c, down_c, hold, two_wire;
  logic inhibit_r, inhibit_nxt, run3_r, run3_nxt, dir3_r, dir3_nxt, sample_tick_r;
  logic [1:0] cmd2, run_nxt;
  logic [31:0] tick_cnt_r;
  logic [26:0] ud_acc_r;
  logic [13:0] rate;
  int ud_sum, src, p_cl, ao_span, lvl;
  assign pin_raw = {input_terminal_x_in, freq_down_in, freq_up_in, reverse_pushbutton_in,
                    stop_pushbutton_in, run_pushbutton_in, reverse_run_input_in,
                    forward_run_input_in};
  // A bit changes only once the second and third stages agree
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
      pin_s3_r <= '0;
      pin_c_r <= '0;
    end else begin
      pin_s1_r <= pin_raw;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
      pin_c_r <= (pin_s2_r & pin_s3_r) | (pin_c_r & (pin_s2_r ^ pin_s3_r));
    end
  end

  assign {down_c, up_c, rev_pb_c, stop_pb_c, run_pb_c, rev_c, fwd_c} =
         pin_c_r[terminal_io_pkg::PIN_DOWN:terminal_io_pkg::PIN_FWD];
  // Hold is any terminal assigned the three-wire function
  always_comb begin
    hold = 1'b0;
    for (int i = 0; i < TERM_N; i++) begin
      if (term_func_in[i] == terminal_io_pkg::FUNC_THREE_WIRE) begin
        hold = hold | pin_c_r[terminal_io_pkg::PIN_FIXED + i];
      end
    end
  end
  // Two-wire decode, {reverse, forward}
  always_comb begin
    two_wire = 1'b0;
    cmd2 = 2'b00;
    case (terminal_command_mode_param_in)
      terminal_io_pkg::MODE_2W_DIR: begin
        two_wire = 1'b1;
        cmd2 = {rev_c & ~fwd_c, fwd_c & ~rev_c};
      end
      terminal_io_pkg::MODE_2W_EN: begin
        two_wire = 1'b1;
        cmd2 = {fwd_c & rev_c, fwd_c & ~rev_c};
      end
      default: cmd2 = 2'b00;
    endcase
  end
  // Outside stop with run held latches an inhibit until the command drops
  always_comb begin
    inhibit_nxt = inhibit_r;
    if (two_wire && ext_stop_in && cmd2 != 2'b00) begin
      inhibit_nxt = 1'b1;
    end else if (!two_wire || cmd2 == 2'b00) begin
      inhibit_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      inhibit_r <= 1'b0;
    end else begin
      inhibit_r <= inhibit_nxt;
    end
  end
  // Three-wire latch; stop and loss of hold win over any start press
  always_comb begin
    run3_nxt = run3_r;
    dir3_nxt = dir3_r;
    case (terminal_command_mode_param_in)
      terminal_io_pkg::MODE_3W_DIR: begin
        if (!hold || stop_pb_c || ext_stop_in) begin
          run3_nxt = 1'b0;
        end else if (run_pb_c) begin
          run3_nxt = 1'b1;
        end
        dir3_nxt = rev_c;
      end
      terminal_io_pkg::MODE_3W_SEP: begin
        if (!hold || stop_pb_c || ext_stop_in) begin
          run3_nxt = 1'b0;
        end else if (run_pb_c) begin
          run3_nxt = 1'b1;
          dir3_nxt = 1'b0;
        end else if (rev_pb_c) begin
          run3_nxt = 1'b1;
          dir3_nxt = 1'b1;
        end
      end
      default: run3_nxt = 1'b0;
    endcase
  end
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      run3_r <= 1'b0;
      dir3_r <= 1'b0;
    end else begin
      run3_r <= run3_nxt;
      dir3_r <= dir3_nxt;
    end
  end

  always_comb begin
    if (two_wire) begin
      run_nxt = (inhibit_r || ext_stop_in) ? 2'b00 : cmd2;
    end else begin
      run_nxt = {run3_nxt & dir3_nxt, run3_nxt & ~dir3_nxt};
    end
  end
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      {run_rev_out, run_fwd_out} <= 2'b00;
    end else begin
      {run_rev_out, run_fwd_out} <= run_nxt;
    end
  end
  // Up/down: fractional accumulator steps 0.01 Hz each time it passes the clock rate
  assign rate = (updown_rate_param_in < terminal_io_pkg::RATE_MIN) ? terminal_io_pkg::RATE_MIN :
                (updown_rate_param_in > terminal_io_pkg::RATE_MAX) ? terminal_io_pkg::RATE_MAX :
                updown_rate_param_in;
  assign ud_sum = int'(ud_acc_r) + int'(rate);

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      ud_acc_r <= '0;
      freq_setpoint_out <= '0;
    end else begin
      if (up_c == down_c) begin
        ud_acc_r <= '0;
      end else if (ud_sum >= UPDOWN_DIV) begin
        ud_acc_r <= 27'(ud_sum - UPDOWN_DIV);
        if (up_c && freq_setpoint_out < max_freq_in) begin
          freq_setpoint_out <= freq_setpoint_out + 16'h0001;
        end else if (down_c && freq_setpoint_out != 16'h0000) begin
          freq_setpoint_out <= freq_setpoint_out - 16'h0001;
        end
      end else begin
        ud_acc_r <= 27'(ud_sum);
      end
      // A lowered maximum pulls the setpoint down with it
      if (freq_setpoint_out > max_freq_in) begin
        freq_setpoint_out <= max_freq_in;
      end
    end
  end
  // Shared sample tick for both input filters
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      tick_cnt_r <= '0;
      sample_tick_r <= 1'b0;
    end else if (tick_cnt_r == 32'(SAMPLE_TICK_CYCLES - 1)) begin
      tick_cnt_r <= '0;
      sample_tick_r <= 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
      sample_tick_r <= 1'b0;
    end
  end

  analog_input_scaler #(.RAW_W(AIN_W)) u_vi_scale (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .sample_tick_in(sample_tick_r),
    .raw_in(voltage_analog_input_in),
    .cfg_in(vi_cfg_in),
    .pct_out(vi_pct_out)
  );

  analog_input_scaler #(.RAW_W(AIN_W)) u_ci_scale (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .sample_tick_in(sample_tick_r),
    .raw_in(current_analog_input_in),
    .cfg_in(ci_cfg_in),
    .pct_out(ci_pct_out)
  );

  function automatic logic pick_status(input logic [3:0] sel,
                                       input terminal_io_pkg::drive_status_t st);
    logic v;
    v = 1'b0;
    case (sel)
      terminal_io_pkg::DO_FREQ_REACHED: v = st.freq_reached;
      terminal_io_pkg::DO_LEVEL_DETECT: v = st.level_detect;
      terminal_io_pkg::DO_FAULT: v = st.fault;
      terminal_io_pkg::DO_FWD_RUN: v = st.fwd_running;
      terminal_io_pkg::DO_REV_RUN: v = st.rev_running;
      terminal_io_pkg::DO_BELOW_START: v = st.below_start;
      terminal_io_pkg::DO_UPPER_LIMIT: v = st.at_upper;
      terminal_io_pkg::DO_LOWER_LIMIT: v = st.at_lower;
      default: v = 1'b0;
    endcase
    return v;
  endfunction : pick_status
  // One register stage only, so a fault reaches the pin on the next edge
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      transistor_output_out <= 1'b0;
      relay_output_out <= 1'b0;
    end else begin
      transistor_output_out <= pick_status(transistor_sel_in, drive_status_in);
      relay_output_out <= pick_status(relay_sel_in, drive_status_in);
    end
  end
  // Analog output: negative input percentages read as zero
  always_comb begin
    case (ao_cfg_in.sel)
      terminal_io_pkg::AO_SET_FREQ: src = int'(drive_meas_in.set_freq);
      terminal_io_pkg::AO_RUN_FREQ: src = int'(drive_meas_in.run_freq);
      terminal_io_pkg::AO_CURRENT: src = int'(drive_meas_in.current);
      terminal_io_pkg::AO_VOLTAGE: src = int'(drive_meas_in.voltage);
      terminal_io_pkg::AO_SPEED: src = int'(drive_meas_in.speed);
      terminal_io_pkg::AO_POWER: src = int'(drive_meas_in.power);
      terminal_io_pkg::AO_TORQUE: src = int'(drive_meas_in.torque);
      terminal_io_pkg::AO_VI: src = (vi_pct_out < 0) ? 0 : int'(vi_pct_out);
      terminal_io_pkg::AO_CI: src = (ci_pct_out < 0) ? 0 : int'(ci_pct_out);
      default: src = 0;
    endcase
    p_cl = src;
    if (src < int'(ao_cfg_in.lo_pct)) begin
      p_cl = int'(ao_cfg_in.lo_pct);
    end else if (src > int'(ao_cfg_in.hi_pct)) begin
      p_cl = int'(ao_cfg_in.hi_pct);
    end
    ao_span = int'(ao_cfg_in.hi_pct) - int'(ao_cfg_in.lo_pct);
    lvl = int'(ao_cfg_in.lo_lv) * terminal_io_pkg::CFG_V_TO_RAW;
    if (ao_span > 0) begin
      lvl = lvl + (p_cl - int'(ao_cfg_in.lo_pct))
          * (int'(ao_cfg_in.hi_lv) - int'(ao_cfg_in.lo_lv))
          * terminal_io_pkg::CFG_V_TO_RAW / ao_span;
    end
    if (ao_cfg_in.is_current) begin
      lvl = lvl * terminal_io_pkg::AO_MA_PER_HALF_V;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      analog_output_out <= '0;
    end else begin
      analog_output_out <= 12'(lvl);
    end
  end
  sequence s_halted_by_other;
    two_wire && (run_fwd_out || run_rev_out) && ext_stop_in && cmd2 != 2'b00;
  endsequence
  sequence s_stop_cleared;
    two_wire && !ext_stop_in && cmd2 != 2'b00 && $stable(cmd2);
  endsequence
  a_run_exclusive: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    !(run_fwd_out && run_rev_out))
    else $error("forward and reverse commanded together");
  a_mode0_both_stop: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (terminal_command_mode_param_in == terminal_io_pkg::MODE_2W_DIR && fwd_c && rev_c)
    |=> (!run_fwd_out && !run_rev_out))
    else $error("mode 0 with both inputs did not stop");
  a_mode1_reverse: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (terminal_command_mode_param_in == terminal_io_pkg::MODE_2W_EN && fwd_c && rev_c
      && !inhibit_r && !ext_stop_in)
    |=> (run_rev_out && !run_fwd_out))
    else $error("mode 1 enable with reverse did not run reverse");
  a_mode1_no_enable: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (terminal_command_mode_param_in == terminal_io_pkg::MODE_2W_EN && !fwd_c)
    |=> (!run_fwd_out && !run_rev_out))
    else $error("mode 1 without enable did not stop");
  a_restart_blocked: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    s_halted_by_other ##1 s_stop_cleared |=> (!run_fwd_out && !run_rev_out))
    else $error("drive restarted without fresh run activation");
  a_hold_drop_stop: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (!two_wire && !hold) |=> (!run_fwd_out && !run_rev_out))
    else $error("three-wire run without hold input");
  a_three_fwd_start: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (terminal_command_mode_param_in == terminal_io_pkg::MODE_3W_SEP && hold && run_pb_c
      && !stop_pb_c && !ext_stop_in) |=> run_fwd_out)
    else $error("mode 3 run button did not start forward");
  a_updown_step: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    ($changed(freq_setpoint_out) && $past(max_freq_in) == max_freq_in)
    |-> (freq_setpoint_out == $past(freq_setpoint_out) + 16'h0001
      || freq_setpoint_out == $past(freq_setpoint_out) - 16'h0001))
    else $error("setpoint moved by more than one step");
  a_fault_route: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (relay_sel_in == terminal_io_pkg::DO_FAULT && drive_status_in.fault) |=> relay_output_out)
    else $error("fault not shown on relay output");
  a_reserved_off: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (transistor_sel_in > terminal_io_pkg::DO_LOWER_LIMIT) |=> !transistor_output_out)
    else $error("reserved selection drove transistor output");
endmodule : terminal_command_io

// ==== tb/operator_panel_model.sv ====
`timescale 1ns/1ps
module operator_panel_model (
  // Clock
  input wire logic clk_sys_in,
  // Switch and button levels
  output logic [5:0] pins_out
);
  // Order: fwd, rev, run, stop, reverse button, hold
  initial pins_out = 6'h00;
  // Contacts move just after an edge so the sampling edge sees a settled level
  task automatic press(input logic [5:0] v);
    @(posedge clk_sys_in);
    #1 pins_out = v;
  endtask : press
endmodule : operator_panel_model

// ==== tb/terminal_command_io_bench.sv ====
`timescale 1ns/1ps
module terminal_command_io_bench;
  logic clk_sys_in, rst_in, ext_stop, forward_run_input, reverse_run_input, tx, rl;
  logic [5:0] pins;
  logic [1:0] mode, ud;
  logic [3:0] tx_sel, rl_sel;
  logic [10:0] vi_raw, ci_raw;
  logic [15:0] fsp;
  logic [13:0] rate;
  terminal_io_pkg::drive_meas_t meas;
  logic signed [11:0] vi_pct, ci_pct;
  logic [11:0] ao;
  terminal_io_pkg::ain_cfg_t vi_cfg, ci_cfg;
  terminal_io_pkg::ao_cfg_t ao_cfg;
  terminal_io_pkg::drive_status_t st;
  int bad_count, num_checks;
  operator_panel_model i_panel (.clk_sys_in(clk_sys_in), .pins_out(pins));
  terminal_command_io #(.SAMPLE_TICK_CYCLES(10), .UPDOWN_DIV(1000)) i_dut (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .forward_run_input_in(pins[0]),
    .reverse_run_input_in(pins[1]), .run_pushbutton_in(pins[2]),
    .stop_pushbutton_in(pins[3]), .reverse_pushbutton_in(pins[4]),
    .freq_up_in(ud[0]), .freq_down_in(ud[1]), .input_terminal_x_in({3'h0, pins[5]}),
    .terminal_command_mode_param_in(mode), .term_func_in(20'h00003),
    .updown_rate_param_in(rate), .max_freq_in(16'h03e8), .vi_cfg_in(vi_cfg),
    .ci_cfg_in(ci_cfg), .transistor_sel_in(tx_sel), .relay_sel_in(rl_sel),
    .ao_cfg_in(ao_cfg), .ext_stop_in(ext_stop), .drive_status_in(st),
    .drive_meas_in(meas), .voltage_analog_input_in(vi_raw),
    .current_analog_input_in(ci_raw), .run_fwd_out(forward_run_input), .run_rev_out(reverse_run_input),
    .freq_setpoint_out(fsp), .vi_pct_out(vi_pct), .ci_pct_out(ci_pct),
    .transistor_output_out(tx), .relay_output_out(rl), .analog_output_out(ao));
  initial begin
    clk_sys_in = 1'b0;
    forever #4 clk_sys_in = ~clk_sys_in;
  end
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask : cyc
  task automatic press_chk(input logic [5:0] p, input logic [1:0] e);
    i_panel.press(p);
    cyc(6);
    chk("run", e, {forward_run_input, reverse_run_input});
  endtask : press_chk
  // Table holds {fwd, rev} for each input pair, pair 0 in the low bits
  task automatic two_wire(input logic [1:0] m, input logic [7:0] tbl);
    mode = m;
    for (int i = 0; i < 4; i++) begin
      press_chk(6'(i), tbl[2*i+:2]);
    end
    press_chk(6'h00, 2'h0);
  endtask : two_wire
  task automatic outside_stop;
    mode = 2'h0;
    press_chk(6'h01, 2'h2);
    ext_stop = 1'b1;
    cyc(1);
    ext_stop = 1'b0;
    cyc(6);
    chk("run held", 2'h0, {forward_run_input, reverse_run_input});
    press_chk(6'h00, 2'h0);
    press_chk(6'h01, 2'h2);
    press_chk(6'h00, 2'h0);
  endtask : outside_stop
  task automatic three_wire;
    mode = 2'h3;
    press_chk(6'h20, 2'h0);
    press_chk(6'h24, 2'h2);
    press_chk(6'h20, 2'h2);
    press_chk(6'h28, 2'h0);
    press_chk(6'h30, 2'h1);
    press_chk(6'h28, 2'h0);
    mode = 2'h2;
    press_chk(6'h26, 2'h1);
    press_chk(6'h24, 2'h2);
    press_chk(6'h00, 2'h0);
  endtask : three_wire
  task automatic routing;
    // Code 1 picks the top status bit, code 8 the bottom one
    for (int c = 1; c < 9; c++) begin
      tx_sel = 4'(c);
      st = 8'h80 >> (c - 1);
      cyc(2);
      chk("transistor code", 1'b1, tx);
      st = ~st;
      cyc(2);
      chk("transistor other", 1'b0, tx);
    end
    tx_sel = 4'h9;
    st = 8'hff;
    cyc(2);
    chk("relay", 1'b1, rl);
    chk("transistor reserved", 1'b0, tx);
    tx_sel = 4'h0;
    st.fault = 1'b0;
    cyc(2);
    chk("relay off", 1'b0, rl);
    chk("transistor none", 1'b0, tx);
  endtask : routing
  task automatic analog;
    vi_raw = 11'h1f4;
    ci_raw = 11'h3e8;
    cyc(30);
    chk("vi mid", 12'h1f4, vi_pct);
    chk("ci ma", 12'h1f4, ci_pct);
    vi_cfg.hi_v = 7'h32;
    vi_raw = 11'h320;
    ao_cfg.sel = 4'h7;
    cyc(30);
    chk("vi clamp", 12'h3e8, vi_pct);
    chk("ao full", 12'h3e8, ao);
    ao_cfg.sel = 4'h4;
    meas.speed = 10'h1f4;
    cyc(2);
    chk("ao speed", 12'h1f4, ao);
    ao_cfg.is_current = 1'b1;
    cyc(2);
    chk("ao ma", 12'h3e8, ao);
    ao_cfg.sel = 4'h9;
    cyc(2);
    chk("ao reserved", 12'h000, ao);
  endtask : analog
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : print_verdict
  initial begin
    {bad_count, num_checks} = '0;
    {ext_stop, ud, mode, st, meas} = '0;
    rate = terminal_io_pkg::RATE_DEFAULT;
    tx_sel = 4'h1;
    rl_sel = 4'h3;
    {vi_raw, ci_raw} = '0;
    vi_cfg = '{7'h00, 12'sh000, 7'h64, 12'sh3e8, 7'h00, 1'b0};
    ci_cfg = '{7'h00, 12'sh000, 7'h64, 12'sh3e8, 7'h00, 1'b1};
    ao_cfg = '{4'h0, 10'h000, 7'h00, 10'h3e8, 7'h64, 1'b0};
    rst_in = 1'b1;
    cyc(2);
    rst_in = 1'b0;
    cyc(4);
    two_wire(2'h0, 8'h18);
    two_wire(2'h1, 8'h48);
    outside_stop();
    three_wire();
    routing();
    analog();
    ud = 2'h1;
    cyc(200);
    // Step lands every 20 cycles, so allow one step of phase slack
    chk("setpoint", 1'b1, fsp >= 16'h0008 && fsp <= 16'h000a);
    // Down runs longer than up did, so the floor at zero must be reached
    ud = 2'h2;
    cyc(240);
    chk("setpoint down", 16'h0000, fsp);
    print_verdict();
  end
endmodule : terminal_command_io_bench
